// File: core/sac_pkg.sv
// What this block does
// - A conversion starts when the read strobe falls while chip select and upper byte select are both low and the result buffer is not full.
// - With upper byte select high no conversion is started, so that read only returns data.
// - Read strobe and upper byte select are heeded only while chip select is low.
// - The twelve result pins are driven only while chip select and read strobe are both low.
// - Busy is held low for the whole conversion and returns high when it is done.
// - Upper byte select low gives the full word; high gives the top four bits on top and bottom groups, middle low.
// - The result is straight binary, bit 11 most significant and bit 0 least.
// - The clock output pin is always the inverse of the clock input pin.
// - A running conversion is never restarted, and the host expects no start before busy is high again.
// - The top bit is decided at the second falling converter clock edge after start, then one bit per edge.
// - At the end of a conversion the bit search register is copied into the twelve bit output latch.
package sac_pkg;

	// ==========================================
	// Widths and field layout
	localparam int RESULT_BITS   = 12;
	localparam int UPPER_LSB     = 8;   // Top nibble of the result
	localparam int MIDDLE_LSB    = 4;   // Middle nibble, forced low in upper byte mode
	localparam int NIBBLE_BITS   = 4;
	localparam int SYNC_STAGES   = 3;
	localparam int FIFO_DEPTH    = 16;

	// ==========================================
	// Conversion schedule in converter clock falling edges
	localparam int TRIAL_EDGE    = 1;   // Top bit trial placed
	localparam int MSB_EDGE      = 2;   // Top bit decided
	localparam int LAST_EDGE     = MSB_EDGE + RESULT_BITS - 1;

	// ==========================================
	// Reset values
	localparam logic [11:0] RESULT_RESET = 12'h0000;
	localparam logic        BUSY_IDLE_N  = 1'b1;

	// ==========================================
	// Host timing expected of the far side
	localparam int CLK_PERIOD_NS      = 10;
	localparam int READ_GAP_TIME_NS   = 200;
	localparam int READ_GAP_CYCLES    = (READ_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACQUIRE_TIME_NS    = 1000;
	localparam int ACQUIRE_CYCLES     = (ACQUIRE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================
	// Types
	typedef struct packed {
		logic csN;
		logic rdN;
		logic upperByteSelect;
	} sac_host_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_CONVERT = 2'b01,
		ST_LATCH   = 2'b10,
		ST_RELEASE = 2'b11
	} sac_state_t;

endpackage : sac_pkg

// File: core/sac_fifo.sv
`timescale 1ns/1ns
module sac_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             inValid,
	output      logic             inReady,
	input  wire logic [WIDTH-1:0] inData,
	output      logic             outValid,
	input  wire logic             outReady,
	output      logic [WIDTH-1:0] outData
);

	// ==========================================
	// Elaboration check
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_badParam
			$error("sac_fifo needs a power of two depth of at least 2");
		end
	endgenerate

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	wire              push;
	wire              pop;

	// Handshake decode
	assign inReady = (count != DEPTH[AW:0]);
	assign push    = inValid && inReady;
	assign pop     = (count != '0) && (!outValid || outReady);

	// Storage write
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// Pointers and fill level
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			wrPtr <= push ? wrPtr + 1'b1 : wrPtr;
			rdPtr <= pop ? rdPtr + 1'b1 : rdPtr;
			count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end

	// Registered read side
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			outValid <= 1'b0;
			outData  <= '0;
		end else if (pop) begin
			outValid <= 1'b1;
			outData  <= mem[rdPtr];
		end else if (outReady) begin
			outValid <= 1'b0;
		end
	end

endmodule : sac_fifo

// File: core/sac_adc_ctrl.sv
`timescale 1ns/1ns
module sac_adc_ctrl
	import sac_pkg::*;
#(
	parameter int RES_BITS = sac_pkg::RESULT_BITS,
	parameter int DEPTH    = sac_pkg::FIFO_DEPTH
) (
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	input  wire sac_pkg::sac_host_t  hostPins,
	input  wire logic                clkIn,
	output      logic                clkOut,
	input  wire logic                compareHigh,
	output      logic [RES_BITS-1:0] dacCode,
	output      logic                busyN,
	output      logic [RES_BITS-1:0] resultOutputPins,
	output      logic                resultOe,
	output      logic                streamValid,
	input  wire logic                streamReady,
	output      logic [RES_BITS-1:0] streamData
);

	// ==========================================
	// Elaboration check
	generate
		if (RES_BITS != RESULT_BITS) begin : g_badWidth
			$error("sac_adc_ctrl serves a twelve bit result only");
		end
		if (LAST_EDGE > 15) begin : g_badSchedule
			$error("sac_adc_ctrl edge counter too narrow for the schedule");
		end
		if (DEPTH < 2) begin : g_badDepth
			$error("sac_adc_ctrl needs a result buffer of at least two words");
		end
	endgenerate

	// Bit positions in the synchronised pin vector
	localparam int NPIN = 5;
	localparam int P_CLK = 4;
	localparam int P_CS  = 3;
	localparam int P_RD  = 2;
	localparam int P_UBS = 1;
	localparam int P_CMP = 0;

	// ==========================================
	// Pin input synchronisers
	// Raw pins and the three synchroniser stages
	wire  [NPIN-1:0] rawPins;
	logic [NPIN-1:0] syncA;
	logic [NPIN-1:0] syncB;
	logic [NPIN-1:0] syncC;
	logic [NPIN-1:0] pinLevel;

	// Placed by index so the order cannot drift from the position names
	assign rawPins[P_CLK] = clkIn;
	assign rawPins[P_CS]  = hostPins.csN;
	assign rawPins[P_RD]  = hostPins.rdN;
	assign rawPins[P_UBS] = hostPins.upperByteSelect;
	assign rawPins[P_CMP] = compareHigh;

	// Three stages; level moves once the last two agree
	genvar gp;
	generate
		for (gp = 0; gp < NPIN; gp++) begin : g_pin
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					syncA[gp]    <= 1'b1;
					syncB[gp]    <= 1'b1;
					syncC[gp]    <= 1'b1;
					pinLevel[gp] <= 1'b1;
				end else begin
					syncA[gp]    <= rawPins[gp];
					syncB[gp]    <= syncA[gp];
					syncC[gp]    <= syncB[gp];
					pinLevel[gp] <= (syncB[gp] == syncC[gp]) ? syncC[gp] : pinLevel[gp];
				end
			end
		end
	endgenerate

	// ==========================================
	// Edge detection on settled levels
	// Previous settled levels and decoded strobes
	logic prevClk;
	logic prevRd;
	wire  csLow;
	wire  rdLow;
	wire  ubsHigh;
	wire  clkFall;
	wire  rdFall;

	// Levels one cycle back; idle high so reset makes no false edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prevClk <= 1'b1;
			prevRd  <= 1'b1;
		end else begin
			prevClk <= pinLevel[P_CLK];
			prevRd  <= pinLevel[P_RD];
		end
	end

	// Strobes count only under chip select
	assign csLow   = !pinLevel[P_CS];
	assign rdLow   = csLow && !pinLevel[P_RD];
	assign ubsHigh = csLow && pinLevel[P_UBS];
	assign clkFall = prevClk && !pinLevel[P_CLK];
	assign rdFall  = csLow && prevRd && !pinLevel[P_RD];

	// Inverted clock straight back out
	assign clkOut = ~clkIn;

	// ==========================================
	// Conversion sequencer
	// Sequencer state and bit search datapath
	sac_state_t          state;
	sac_state_t          next_state;
	logic [3:0]          edgeCnt;
	logic [RES_BITS-1:0] bitSearch;
	logic [RES_BITS-1:0] outLatch;
	logic [RES_BITS-1:0] trialMask;
	wire                 fifoInReady;
	wire                 startReq;
	wire                 decideNow;
	wire                 lastEdge;
	wire  [3:0]          edgeNext;
	wire  [3:0]          bitPos;
	wire                 trialNow;
	wire  [RES_BITS-1:0] decidedBits;

	// Start needs select low; a running conversion or full buffer ignores it
	assign startReq  = rdFall && !ubsHigh && (state == ST_IDLE) && fifoInReady;
	assign edgeNext  = edgeCnt + 4'h1;
	assign decideNow = (state == ST_CONVERT) && clkFall && (edgeNext >= 4'(MSB_EDGE));
	assign lastEdge  = decideNow && (edgeNext == 4'(LAST_EDGE));
	assign bitPos    = 4'(LAST_EDGE) - edgeNext;
	assign trialNow  = (state == ST_CONVERT) && clkFall && (edgeNext == 4'(TRIAL_EDGE));

	// Next state
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (startReq) begin
					next_state = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (lastEdge) begin
					next_state = ST_LATCH;
				end
			end
			ST_LATCH: begin
				next_state = ST_RELEASE;
			end
			ST_RELEASE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Falling edge count since start
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			edgeCnt <= 4'h0;
		end else if (startReq) begin
			edgeCnt <= 4'h0;
		end else if (state == ST_CONVERT && clkFall) begin
			edgeCnt <= edgeNext;
		end
	end

	// Trial bit one position below the decided one
	always_comb begin
		trialMask = '0;
		if (bitPos != 4'h0) begin
			trialMask[bitPos - 4'h1] = 1'b1;
		end
	end

	// ==========================================
	// Per bit next value at a decision edge
	genvar gb;
	generate
		for (gb = 0; gb < RES_BITS; gb++) begin : g_bit
			assign decidedBits[gb] = (bitPos == 4'(gb))
				? pinLevel[P_CMP] : (bitSearch[gb] | trialMask[gb]);
		end
	endgenerate

	// Bit search: clear, place top trial, keep or drop each trial bit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bitSearch <= RESULT_RESET;
		end else if (startReq) begin
			bitSearch <= RESULT_RESET;
		end else if (trialNow) begin
			bitSearch <= {1'b1, {(RES_BITS-1){1'b0}}};
		end else if (decideNow) begin
			bitSearch <= decidedBits;
		end
	end

	// Trial code to the analog side
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dacCode <= RESULT_RESET;
		end else begin
			dacCode <= bitSearch;
		end
	end

	// ==========================================
	// Output latch loaded at the end of a conversion
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			outLatch <= RESULT_RESET;
		end else if (state == ST_LATCH) begin
			outLatch <= bitSearch;
		end
	end

	// Busy low from start until the cycle after the latch load
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busyN <= BUSY_IDLE_N;
		end else if (startReq) begin
			busyN <= 1'b0;
		end else if (state == ST_RELEASE) begin
			busyN <= 1'b1;
		end
	end

	// ==========================================
	// Read port
	// Pin data before its register
	wire [RES_BITS-1:0] next_resultOutputPins;
	wire [NIBBLE_BITS-1:0] upperNib;

	assign upperNib = outLatch[UPPER_LSB +: NIBBLE_BITS];
	// Word or upper byte arrangement, one pin group at a time
	genvar gn;
	generate
		for (gn = 0; gn < RES_BITS / NIBBLE_BITS; gn++) begin : g_group
			if (gn * NIBBLE_BITS == MIDDLE_LSB) begin : g_middle
				assign next_resultOutputPins[gn*NIBBLE_BITS +: NIBBLE_BITS] = ubsHigh
					? {NIBBLE_BITS{1'b0}}
					: outLatch[gn*NIBBLE_BITS +: NIBBLE_BITS];
			end else begin : g_outer
				assign next_resultOutputPins[gn*NIBBLE_BITS +: NIBBLE_BITS] = ubsHigh
					? upperNib
					: outLatch[gn*NIBBLE_BITS +: NIBBLE_BITS];
			end
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			resultOutputPins <= RESULT_RESET;
		end else begin
			resultOutputPins <= next_resultOutputPins;
		end
	end

	// Drivers on only under select and read, in step with the pin data
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			resultOe <= 1'b0;
		end else begin
			resultOe <= rdLow;
		end
	end

	// ==========================================
	// Result stream buffer
	sac_fifo #(
		.WIDTH (RES_BITS),
		.DEPTH (DEPTH)
	) u_fifo (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.inValid  (state == ST_LATCH),
		.inReady  (fifoInReady),
		.inData   (bitSearch),
		.outValid (streamValid),
		.outReady (streamReady),
		.outData  (streamData)
	);

endmodule : sac_adc_ctrl

// File: verif/sac_adc_ctrl_asserts.sv
`timescale 1ns/1ns
module sac_adc_ctrl_asserts
	import sac_pkg::*;
#(
	parameter int RES_BITS = 12
) (
	input wire logic                core_clk,
	input wire logic                rst_n,
	input wire sac_pkg::sac_host_t  hostPins,
	input wire logic                clkIn,
	input wire logic                clkOut,
	input wire logic [RES_BITS-1:0] dacCode,
	input wire logic                busyN,
	input wire logic [RES_BITS-1:0] resultOutputPins,
	input wire logic                resultOe,
	input wire logic                streamValid,
	input wire logic                streamReady
);
	// Bench converter clock is 20 core cycles; busy falls 5 cycles after the strobe
	localparam int CONV_MIN = 235;
	localparam int CONV_MAX = 255;
	logic [8:0] lowCnt;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Cycles spent with busy low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			lowCnt <= 9'h000;
		else
			lowCnt <= busyN ? 9'h000 : lowCnt + 9'h001;
	end
	// ==========================================
	// Checks
	clk_invert_a: assert property (clkOut == !clkIn) else $error("clock out not inverted");
	oe_idle_a: assert property (hostPins.rdN [*6] |-> !resultOe) else $error("pins driven while idle");
	ubs_nostart_a: assert property (hostPins.upperByteSelect [*8] |-> !$fell(busyN))
		else $error("start with upper byte select high");
	cs_nostart_a: assert property (hostPins.csN [*8] |-> !$fell(busyN)) else $error("start unselected");
	conv_len_a: assert property ($rose(busyN) |-> lowCnt >= CONV_MIN && lowCnt <= CONV_MAX)
		else $error("conversion length off");
	sar_clear_a: assert property ($fell(busyN) |=> dacCode == '0) else $error("search not cleared");
	msb_trial_a: assert property (!busyN && $past(dacCode) == '0 && dacCode != '0 |-> dacCode == 12'h800)
		else $error("first trial not top bit");
	upper_map_a: assert property ((!hostPins.csN && hostPins.upperByteSelect) [*8] |->
		resultOutputPins[7:4] == 4'h0 && resultOutputPins[3:0] == resultOutputPins[11:8]) else $error("upper map");
	dac_busy_a: assert property ($changed(dacCode) |-> !$past(busyN)) else $error("code moved while idle");
	cover property ($fell(busyN));
	cover property ($rose(busyN));
	cover property (streamValid && streamReady);
endmodule : sac_adc_ctrl_asserts

bind sac_adc_ctrl sac_adc_ctrl_asserts #(.RES_BITS(RES_BITS)) i_asserts (.core_clk(core_clk), .rst_n(rst_n),
	.hostPins(hostPins), .clkIn(clkIn), .clkOut(clkOut), .dacCode(dacCode), .busyN(busyN),
	.resultOutputPins(resultOutputPins), .resultOe(resultOe), .streamValid(streamValid), .streamReady(streamReady));

// File: verif/sac_host_model.sv
`timescale 1ns/1ns
module sac_host_model
	import sac_pkg::*;
(
	input  wire logic          core_clk,
	input  wire logic          clkIn,
	input  wire logic [11:0]   resultOutputPins,
	input  wire logic          resultOe,
	output sac_pkg::sac_host_t hostPins
);
	// Bus idle, nothing selected
	initial hostPins = '{csN: 1'b1, rdN: 1'b1, upperByteSelect: 1'b0};
	// Strobe falls this many core cycles after a converter clock rise
	localparam int START_DELAY = 5;
	// One strobe, returns pins seen at its end
	task automatic pulse(input logic cs, input logic ubs, output logic [11:0] data, output logic oe);
		@(posedge clkIn);
		repeat (START_DELAY) @(posedge core_clk);
		hostPins <= '{csN: cs, rdN: 1'b0, upperByteSelect: ubs};
		repeat (10) @(posedge core_clk);
		#1;
		data = resultOutputPins;
		oe = resultOe;
		@(posedge core_clk);
		hostPins <= '{csN: 1'b1, rdN: 1'b1, upperByteSelect: 1'b0};
		repeat (READ_GAP_CYCLES) @(posedge core_clk);
	endtask : pulse
endmodule : sac_host_model

// File: verif/sac_adc_ctrl_tb.sv
`timescale 1ns/1ns
module sac_adc_ctrl_tb;
	import sac_pkg::*;
	logic        core_clk, rst_n, clkIn, compareHigh, streamReady, clkOut, busyN, resultOe, streamValid, oe;
	sac_host_t   hostPins;
	logic [11:0] dacCode, resultOutputPins, streamData, level, word;
	logic [11:0] expQ[$];
	int          fails, checked;
	// Core clock and free running converter clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		clkIn = 1'b0;
		forever #100 clkIn = ~clkIn; // 200 ns period keeps strobes 45 ns clear of edges
	end
	// Comparator keeps the trial while input at or above code
	assign compareHigh = (level >= dacCode);
	sac_adc_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n), .hostPins(hostPins), .clkIn(clkIn), .clkOut(clkOut),
		.compareHigh(compareHigh), .dacCode(dacCode), .busyN(busyN), .resultOutputPins(resultOutputPins),
		.resultOe(resultOe), .streamValid(streamValid), .streamReady(streamReady), .streamData(streamData));
	sac_host_model i_host (.core_clk(core_clk), .clkIn(clkIn), .resultOutputPins(resultOutputPins),
		.resultOe(resultOe), .hostPins(hostPins));
	// ==========================================
	// Helpers
	task check(input logic [11:0] got, input logic [11:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task test_done;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	task waitIdle;
		for (int n = 0; n < 300 && busyN !== 1'b1; n++)
			@(posedge core_clk);
		if (busyN !== 1'b1) begin
			fails++;
			test_done();
		end
	endtask : waitIdle
	// ==========================================
	// Scenarios
	task t_fill;
		logic [11:0] prev;
		prev = 12'h000;
		for (int i = 0; i < 17; i++) begin
			level <= (i == 16) ? 12'hFFF : 12'(12'h0F1 * i);
			i_host.pulse(1'b0, 1'b0, word, oe);
			check(word, prev);
			check({11'h000, oe}, 12'h001);
			check({11'h000, busyN}, 12'h000);
			i_host.pulse(1'b0, 1'b0, word, oe);
			waitIdle();
			repeat (ACQUIRE_CYCLES) @(posedge core_clk);
			i_host.pulse(1'b0, 1'b1, word, oe);
			check(word, {level[11:8], 4'h0, level[11:8]});
			check({11'h000, busyN}, 12'h001);
			expQ.push_back(level);
			prev = level;
		end
		i_host.pulse(1'b0, 1'b0, word, oe);
		check(word, 12'hFFF);
		check({11'h000, busyN}, 12'h001);
		$display("t_fill done");
	endtask : t_fill
	task t_drain;
		for (int n = 0; n < 400 && expQ.size() > 0; n++) begin
			@(negedge core_clk);
			if (streamValid === 1'b1 && streamReady === 1'b1)
				check(streamData, expQ.pop_front());
			@(posedge core_clk);
			streamReady <= ~streamReady;
		end
		check(12'(expQ.size()), 12'h000);
		repeat (4) @(posedge core_clk);
		check({11'h000, streamValid}, 12'h000);
		$display("t_drain done");
	endtask : t_drain
	task t_refuse;
		i_host.pulse(1'b1, 1'b0, word, oe);
		check({11'h000, oe}, 12'h000);
		check({11'h000, busyN}, 12'h001);
		check({11'h000, clkOut}, {11'h000, ~clkIn});
		$display("t_refuse done");
	endtask : t_refuse
	// Reset then scenarios
	initial begin
		rst_n = 1'b0;
		streamReady = 1'b0;
		level = 12'h000;
		fails = 0;
		checked = 0;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_fill();
		t_drain();
		t_refuse();
		test_done();
	end
endmodule : sac_adc_ctrl_tb
